// File: hw/iets_pkg.sv
/*
 Constants, register map and carrier types of the interrupt and event
 transfer block. Assumes a single 10 MHz clock and AXI4-Lite access.
*/
// What this block does
// - Each node served by vector or transfer
// - Vectored service branches to source vector
// - Transfer moves byte/word, bumps pointers
// - Count down per transfer, zero raises interrupt
// - Eight independent transfer channels
// - Service starts 7 or 11 clocks after request
// - 112 nodes with request, enable, priority
// - Select registers choose shared node source
// - Router: 4 inputs, matrix, 4 gates
// - Rising, falling or both edge detection
// - Gates pass events on pattern match/miss
// - Hardware trap branches to trap vector
// - Each trap sets its own flag bit
// - Trap preempts unless same or higher trap active
// - No interrupt or transfer during trap
// - Three service pins raise system traps
// - Software trap vectors to given number
// - Software request flag write raises request
package iets_pkg;
   // ----------------------------------------
   // Sizes and timing
   // ----------------------------------------
   localparam int NODES      = 112;
   localparam int CHANS      = 8;
   localparam int SHARED     = 4;
   localparam int TRAPS      = 8;
   localparam int HW_TRAPS   = 5;
   localparam int LAT_JC_CLK = 7;
   localparam int LAT_NJ_CLK = 11;
   localparam logic [3:0] LAT_JC_LD = 4'(LAT_JC_CLK - 2);
   localparam logic [3:0] LAT_NJ_LD = 4'(LAT_NJ_CLK - 2);
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [9:0] A_CTRL  = 10'h000;
   localparam logic [9:0] A_STAT  = 10'h004;
   localparam logic [9:0] A_MASK  = 10'h008;
   localparam logic [9:0] A_TRAP  = 10'h00C;
   localparam logic [9:0] A_RCFG  = 10'h010;
   localparam logic [9:0] A_ROUTE = 10'h014;
   localparam logic [9:0] A_SSEL  = 10'h018;
   localparam logic [9:0] A_CHAN  = 10'h040;
   localparam logic [9:0] A_CEND  = 10'h0C0;
   localparam logic [9:0] A_NODE  = 10'h200;
   localparam logic [7:0] VEC_TRAP = 8'h00;
   localparam logic [7:0] VEC_NODE = 8'h10;
   localparam logic [3:0] LVL_TRAP = 4'hF;
   localparam logic [1:0] R_OKAY   = 2'h0;
   localparam logic [1:0] R_SLVERR = 2'h2;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] chan;
      logic       xfer;
      logic [3:0] prio;
      logic       en;
      logic       req;
   } iets_node_t;
   typedef struct packed {
      logic       cont;
      logic       inc_dst;
      logic       inc_src;
      logic       word;
      logic [7:0] cnt;
   } iets_chctl_t;
   typedef struct packed {
      logic [15:0] src;
      logic [15:0] dst;
      logic        word;
   } iets_xfer_t;
   typedef struct packed {
      logic       trap;
      logic [3:0] level;
      logic [7:0] vector;
   } iets_svc_t;
   typedef enum logic [1:0] {S_IDLE, S_WAIT, S_OFFER} iets_state_t;
   typedef enum logic [1:0] {K_NODE, K_TRAP, K_SWI} iets_kind_t;
endpackage

// File: hw/iets_top.sv
/*
 Interrupt arbiter, event transfer channels, request router and trap
 logic with an AXI4-Lite register slave. Assumes inputs synchronous to
 aclk and a CPU that answers offers with cpu_take.
*/
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module iets_top #(
   parameter int NODES = iets_pkg::NODES,
   parameter int CHANS = iets_pkg::CHANS
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [9:0]          awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   input  wire logic [9:0]          araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   input  wire logic [NODES-1:0]    src_req,
   input  wire logic [15:0]         shared_src,
   input  wire logic [3:0]          router_in,
   input  wire logic [4:0]          hw_trap,
   input  wire logic [2:0]          srv_pin,
   input  wire logic [3:0]          cpu_prio,
   input  wire logic                cpu_take,
   input  wire logic                cpu_trap_done,
   input  wire logic                swi_valid,
   input  wire logic [6:0]          swi_num,
   output logic                     swi_ready,
   output logic                     cpu_irq_valid,
   output iets_pkg::iets_svc_t      cpu_svc,
   output logic                     xfer_valid,
   output iets_pkg::iets_xfer_t     xfer,
   output logic                     irq
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   iets_pkg::iets_node_t  nodes [NODES];
   iets_pkg::iets_node_t  next_nodes [NODES];
   iets_pkg::iets_chctl_t chc [CHANS], next_chc [CHANS];
   logic [15:0]           chs [CHANS], next_chs [CHANS];
   logic [15:0]           chd [CHANS], next_chd [CHANS];
   logic [31:0] ctrl, next_ctrl, rcfg, next_rcfg;
   logic [15:0] route, next_route;
   logic [7:0]  ssel, next_ssel, tflags, next_tflags;
   logic [7:0]  tpend, next_tpend;
   logic [8:0]  stat, next_stat, mask, next_mask;
   logic [3:0]  rin_q, next_rin_q;
   logic [2:0]  srv_q, next_srv_q;
   logic        trap_busy, next_trap_busy;
   logic [2:0]  trap_idx, next_trap_idx;
   logic        swi_pend, next_swi_pend;
   logic [6:0]  swi_q, next_swi_q;
   iets_pkg::iets_state_t state, next_state;
   iets_pkg::iets_kind_t  kind, next_kind;
   logic [6:0]  sel, next_sel;
   logic        sel_x, next_sel_x;
   logic [3:0]  cnt, next_cnt;
   iets_pkg::iets_svc_t   next_svc;
   iets_pkg::iets_xfer_t  next_xfer;
   logic        next_xfer_valid, was_wait;
   logic        next_bvalid, next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata, rv;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] wm(input logic [31:0] o,
                                      input logic [31:0] d,
                                      input logic [3:0]  s);
      for (int b = 0; b < 4; b++)
         if (s[b])
            o[8*b +: 8] = d[8*b +: 8];
      return o;
   endfunction

   function automatic logic mapped(input logic [9:0] a);
      return (a <= iets_pkg::A_SSEL && a[1:0] == 2'h0)
          || (a >= iets_pkg::A_CHAN && a < iets_pkg::A_CEND
              && a[3:2] != 2'h3)
          || (a >= iets_pkg::A_NODE && int'(a[8:2]) < NODES);
   endfunction

   logic wr, rd, node_go, trap_go, tany, nfound;
   logic [6:0] best;
   logic [3:0] bestp, ev, rout;
   logic [2:0] ti, wc, rc;
   logic [7:0] tev;
   logic       pm;

   assign wr        = awvalid && wvalid && !bvalid;
   assign rd        = arvalid && !rvalid;
   assign awready   = wr;
   assign wready    = wr;
   assign arready   = !rvalid;
   assign swi_ready = !swi_pend;
   assign cpu_irq_valid = state == iets_pkg::S_OFFER;
   assign irq       = |(stat & mask);
   assign wc        = 3'(awaddr[6:4] - 3'h4);
   assign rc        = 3'(araddr[6:4] - 3'h4);

   // ----------------------------------------
   // Router and trap events
   // ----------------------------------------
   always_comb
   begin
      ev = (router_in & ~rin_q & rcfg[3:0])
         | (~router_in & rin_q & rcfg[7:4]);
      pm = router_in == rcfg[11:8];
      for (int k = 0; k < 4; k++)
      begin
         unique case (rcfg[12+2*k +: 2])
            2'h0: rout[k] = |(ev & route[4*k +: 4]);
            2'h1: rout[k] = |(ev & route[4*k +: 4]) && pm;
            2'h2: rout[k] = |(ev & route[4*k +: 4]) && !pm;
            2'h3: rout[k] = 1'b0;
         endcase
      end
      tev = {srv_pin & ~srv_q, hw_trap};
   end

   // ----------------------------------------
   // Arbitration
   // ----------------------------------------
   always_comb
   begin
      nfound = 1'b0;
      best   = 7'h00;
      bestp  = 4'h0;
      for (int i = 0; i < NODES; i++)
         if (nodes[i].req && nodes[i].en
             && (!nfound || nodes[i].prio > bestp))
         begin
            nfound = 1'b1;
            best   = 7'(i);
            bestp  = nodes[i].prio;
         end
      tany = |tpend;
      ti   = 3'h0;
      for (int t = iets_pkg::TRAPS - 1; t >= 0; t--)
         if (tpend[t])
            ti = 3'(t);
      trap_go = tany && (!trap_busy || ti < trap_idx);
      node_go = nfound && !trap_busy && bestp > cpu_prio;
   end

   // ----------------------------------------
   // Register read data
   // ----------------------------------------
   always_comb
   begin
      rv = iets_pkg::RST_WORD;
      if (araddr >= iets_pkg::A_NODE)
         rv = 32'(nodes[araddr[8:2]]);
      else if (araddr >= iets_pkg::A_CHAN)
         unique case (araddr[3:2])
            2'h0: rv = 32'(chc[rc]);
            2'h1: rv = 32'(chs[rc]);
            default: rv = 32'(chd[rc]);
         endcase
      else
         unique case (araddr)
            iets_pkg::A_CTRL:  rv = ctrl;
            iets_pkg::A_STAT:  rv = 32'(stat);
            iets_pkg::A_MASK:  rv = 32'(mask);
            iets_pkg::A_TRAP:  rv = 32'(tflags);
            iets_pkg::A_RCFG:  rv = rcfg;
            iets_pkg::A_ROUTE: rv = 32'(route);
            iets_pkg::A_SSEL:  rv = 32'(ssel);
            default:           rv = iets_pkg::RST_WORD;
         endcase
      if (!mapped(araddr))
         rv = iets_pkg::RST_WORD;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_nodes = nodes;
      next_chc = chc;
      next_chs = chs;
      next_chd = chd;
      next_ctrl = ctrl;
      next_rcfg = rcfg;
      next_route = route;
      next_ssel = ssel;
      next_mask = mask;
      next_stat = stat;
      next_tflags = tflags | tev;
      next_tpend = tpend;
      next_rin_q = router_in;
      next_srv_q = srv_pin;
      next_trap_busy = trap_busy && !cpu_trap_done;
      next_trap_idx = trap_idx;
      next_swi_pend = swi_pend;
      next_swi_q = swi_q;
      next_state = state;
      next_kind = kind;
      next_sel = sel;
      next_sel_x = sel_x;
      next_cnt = cnt;
      next_svc = cpu_svc;
      next_xfer = xfer;
      next_xfer_valid = 1'b0;
      next_bvalid = bvalid && !bready;
      next_bresp = bresp;
      next_rvalid = rvalid && !rready;
      next_rresp = rresp;
      next_rdata = rdata;
      // Bus writes
      if (wr)
      begin
         next_bvalid = 1'b1;
         next_bresp = mapped(awaddr) ? iets_pkg::R_OKAY
                                     : iets_pkg::R_SLVERR;
         if (mapped(awaddr) && awaddr >= iets_pkg::A_NODE)
            next_nodes[awaddr[8:2]] = iets_pkg::iets_node_t'(
               10'(wm(32'(nodes[awaddr[8:2]]), wdata, wstrb)));
         else if (mapped(awaddr) && awaddr >= iets_pkg::A_CHAN)
            unique case (awaddr[3:2])
               2'h0: next_chc[wc] = iets_pkg::iets_chctl_t'(
                        12'(wm(32'(chc[wc]), wdata, wstrb)));
               2'h1: next_chs[wc] = 16'(wm(32'(chs[wc]), wdata, wstrb));
               default: next_chd[wc] = 16'(wm(32'(chd[wc]), wdata, wstrb));
            endcase
         else
            unique case (awaddr)
               iets_pkg::A_CTRL:  next_ctrl = wm(ctrl, wdata, wstrb);
               iets_pkg::A_STAT:  next_stat = stat & ~wdata[8:0];
               iets_pkg::A_MASK:  next_mask = wdata[8:0];
               iets_pkg::A_TRAP:  next_tflags = (tflags & ~wdata[7:0]) | tev;
               iets_pkg::A_RCFG:  next_rcfg = wm(rcfg, wdata, wstrb);
               iets_pkg::A_ROUTE: next_route = wdata[15:0];
               iets_pkg::A_SSEL:  next_ssel = wdata[7:0];
               default: ;
            endcase
      end
      if (rd)
      begin
         next_rvalid = 1'b1;
         next_rdata = rv;
         next_rresp = mapped(araddr) ? iets_pkg::R_OKAY
                                     : iets_pkg::R_SLVERR;
      end
      if (swi_valid && !swi_pend)
      begin
         next_swi_pend = 1'b1;
         next_swi_q = swi_num;
      end
      // Service sequencer
      unique case (state)
         iets_pkg::S_IDLE:
            if (trap_go || (swi_pend && !trap_busy) || node_go)
            begin
               next_state = iets_pkg::S_WAIT;
               next_cnt = ctrl[0] ? iets_pkg::LAT_JC_LD
                                  : iets_pkg::LAT_NJ_LD;
               next_sel_x = 1'b0;
               if (trap_go)
               begin
                  next_kind = iets_pkg::K_TRAP;
                  next_sel = 7'(ti);
                  next_svc = '{1'b1, iets_pkg::LVL_TRAP,
                               iets_pkg::VEC_TRAP + 8'(ti)};
               end
               else if (swi_pend && !trap_busy)
               begin
                  next_kind = iets_pkg::K_SWI;
                  next_sel = swi_q;
                  next_svc = '{1'b0, cpu_prio, 8'(swi_q)};
               end
               else
               begin
                  next_kind = iets_pkg::K_NODE;
                  next_sel = best;
                  next_sel_x = nodes[best].xfer
                     && (chc[nodes[best].chan].cont
                         || chc[nodes[best].chan].cnt != 8'h00);
                  next_svc = '{1'b0, bestp,
                               iets_pkg::VEC_NODE + 8'(best)};
               end
            end
         iets_pkg::S_WAIT:
            if (cnt != 4'h0)
               next_cnt = 4'(cnt - 4'h1);
            else if (sel_x)
            begin
               next_state = iets_pkg::S_IDLE;
               next_xfer_valid = 1'b1;
               next_xfer = '{chs[nodes[sel].chan], chd[nodes[sel].chan],
                             chc[nodes[sel].chan].word};
               begin
                  automatic logic [2:0] c = nodes[sel].chan;
                  automatic logic [15:0] st = chc[c].word ? 16'h0002
                                                          : 16'h0001;
                  if (chc[c].inc_src)
                     next_chs[c] = 16'(chs[c] + st);
                  if (chc[c].inc_dst)
                     next_chd[c] = 16'(chd[c] + st);
                  next_nodes[sel].req = 1'b0;
                  if (!chc[c].cont)
                  begin
                     next_chc[c].cnt = 8'(chc[c].cnt - 8'h01);
                     if (chc[c].cnt == 8'h01)
                     begin
                        next_nodes[sel].req = 1'b1;
                        next_stat[c] = 1'b1;
                     end
                  end
               end
            end
            else
               next_state = iets_pkg::S_OFFER;
         iets_pkg::S_OFFER:
            if (cpu_take)
            begin
               next_state = iets_pkg::S_IDLE;
               unique case (kind)
                  iets_pkg::K_TRAP:
                  begin
                     next_tpend[sel[2:0]] = 1'b0;
                     next_trap_busy = 1'b1;
                     next_trap_idx = sel[2:0];
                     next_stat[8] = 1'b1;
                  end
                  iets_pkg::K_SWI: next_swi_pend = 1'b0;
                  default: next_nodes[sel].req = 1'b0;
               endcase
            end
      endcase
      // Hardware sets win over clears
      next_tpend = next_tpend | tev;
      for (int i = 0; i < NODES; i++)
      begin
         if (i >= NODES - iets_pkg::SHARED)
         begin
            automatic int k = i - (NODES - iets_pkg::SHARED);
            if (shared_src[4*k + int'(ssel[2*k +: 2])])
               next_nodes[i].req = 1'b1;
         end
         else if (src_req[i])
            next_nodes[i].req = 1'b1;
         if (i < 4 && rout[i[1:0]])
            next_nodes[i].req = 1'b1;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < NODES; i++)
            nodes[i] <= '0;
         for (int c = 0; c < CHANS; c++)
         begin
            chc[c] <= '0;
            chs[c] <= '0;
            chd[c] <= '0;
         end
         ctrl <= iets_pkg::RST_WORD;
         rcfg <= iets_pkg::RST_WORD;
         {route, ssel, tflags, tpend, stat, mask} <= '0;
         {rin_q, srv_q, trap_busy, trap_idx, swi_pend, swi_q} <= '0;
         state <= iets_pkg::S_IDLE;
         kind <= iets_pkg::K_NODE;
         {sel, sel_x, cnt, cpu_svc, xfer, xfer_valid, was_wait} <= '0;
         {bvalid, bresp, rvalid, rresp, rdata} <= '0;
      end
      else
      begin
         nodes <= next_nodes;
         chc <= next_chc;
         chs <= next_chs;
         chd <= next_chd;
         ctrl <= next_ctrl;
         rcfg <= next_rcfg;
         route <= next_route;
         ssel <= next_ssel;
         tflags <= next_tflags;
         tpend <= next_tpend;
         stat <= next_stat;
         mask <= next_mask;
         rin_q <= next_rin_q;
         srv_q <= next_srv_q;
         trap_busy <= next_trap_busy;
         trap_idx <= next_trap_idx;
         swi_pend <= next_swi_pend;
         swi_q <= next_swi_q;
         state <= next_state;
         kind <= next_kind;
         sel <= next_sel;
         sel_x <= next_sel_x;
         cnt <= next_cnt;
         cpu_svc <= next_svc;
         xfer <= next_xfer;
         xfer_valid <= next_xfer_valid;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         was_wait <= state == iets_pkg::S_WAIT;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic enter;
   assign enter = state == iets_pkg::S_WAIT && !was_wait;

   property p_xfer_once;
      xfer_valid |-> state == iets_pkg::S_IDLE ##1 !xfer_valid;
   endproperty
   a_xfer_once: assert property (p_xfer_once)
      else $error("transfer pulse longer than one cycle");
   property p_offer_hold;
      cpu_irq_valid && !cpu_take |=> cpu_irq_valid && $stable(cpu_svc);
   endproperty
   a_offer_hold: assert property (p_offer_hold)
      else $error("offer dropped or changed before take");
   property p_lat_jc;
      enter && cnt == iets_pkg::LAT_JC_LD |->
         ##5 state == iets_pkg::S_WAIT ##1 state != iets_pkg::S_WAIT;
   endproperty
   a_lat_jc: assert property (p_lat_jc)
      else $error("cached latency not 7 clocks");
   property p_lat_nj;
      enter && cnt == iets_pkg::LAT_NJ_LD |->
         ##9 state == iets_pkg::S_WAIT ##1 state != iets_pkg::S_WAIT;
   endproperty
   a_lat_nj: assert property (p_lat_nj)
      else $error("uncached latency not 11 clocks");
   property p_trap_flag;
      hw_trap[0] |=> tflags[0];
   endproperty
   a_trap_flag: assert property (p_trap_flag)
      else $error("trap flag not set");
   property p_trap_block;
      trap_busy |-> !xfer_valid && !(enter && kind == iets_pkg::K_NODE);
   endproperty
   a_trap_block: assert property (p_trap_block)
      else $error("service started during trap");
   property p_prio;
      enter && kind == iets_pkg::K_NODE |->
         cpu_svc.level > $past(cpu_prio);
   endproperty
   a_prio: assert property (p_prio)
      else $error("node not above cpu priority");
   property p_sw_req;
      wr && awaddr == iets_pkg::A_NODE && wstrb[0] && wdata[0]
         |=> nodes[0].req;
   endproperty
   a_sw_req: assert property (p_sw_req)
      else $error("software request not raised");

endmodule // iets_top

// File: bench/iets_cpu_model.sv
/*
 CPU-side model: takes each offer after a delay, ends trap services.
 Assumes offers stand until cpu_take and one clock domain.
*/
`timescale 1ns/1ps
module iets_cpu_model (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [3:0]          delay,
   input  wire logic                cpu_irq_valid,
   input  wire iets_pkg::iets_svc_t cpu_svc,
   output logic                     cpu_take,
   output logic                     cpu_trap_done
);
   logic [3:0] wait_cnt;
   logic [2:0] trap_cnt;
   // ----------
   // Offer handshake
   // ----------
   always @(posedge aclk)
   begin
      cpu_take <= 1'b0;
      cpu_trap_done <= trap_cnt == 3'h1;
      trap_cnt <= trap_cnt - 3'(trap_cnt != 3'h0);
      wait_cnt <= 4'h0;
      if (!aresetn)
         trap_cnt <= 3'h0;
      else if (cpu_irq_valid && !cpu_take)
      begin
         wait_cnt <= wait_cnt + 4'h1;
         if (wait_cnt >= delay)
         begin
            cpu_take <= 1'b1;
            if (cpu_svc.trap)
               trap_cnt <= 3'h4;
         end
      end
   end
endmodule // iets_cpu_model

// File: bench/iets_top_tb.sv
/*
 Self-checking bench of the interrupt and transfer block.
 Assumes the CPU model in iets_cpu_model and AXI4-Lite timing.
*/
`timescale 1ns/1ps
module iets_top_tb;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, swi_valid = 0;
   logic [9:0]   awaddr = 0, araddr = 0;
   logic [31:0]  wdata = 0, rdata;
   logic [3:0]   wstrb = 4'hF, router_in = 0, cpu_prio = 0, delay = 0;
   logic [111:0] src_req = 0;
   logic [15:0]  shared_src = 0;
   logic [4:0]   hw_trap = 0;
   logic [2:0]   srv_pin = 0;
   logic [6:0]   swi_num = 0;
   logic [1:0]   bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, swi_ready, irq;
   logic cpu_take, cpu_trap_done, cpu_irq_valid, xfer_valid;
   iets_pkg::iets_svc_t  cpu_svc;
   iets_pkg::iets_xfer_t xfer;
   int n_fail = 0, comparisons = 0;
   logic [33:0] qr[$], qs[$], qx[$];
   localparam logic [36:0] RT [9] = '{{32'h1, 5'h3}, {32'h1, 5'h0},
      {32'h10, 5'h2}, {32'h10, 5'h1}, {32'h2311, 5'h3}, {32'h2311, 5'h1},
      {32'h3011, 5'h2}, {32'h1011, 5'h1}, {32'h1011, 5'h2}};
   always #50 aclk = ~aclk;
   iets_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .src_req,
      .shared_src, .router_in, .hw_trap, .srv_pin, .cpu_prio, .cpu_take,
      .cpu_trap_done, .swi_valid, .swi_num, .swi_ready, .cpu_irq_valid,
      .cpu_svc, .xfer_valid, .xfer, .irq);
   iets_cpu_model cpu (.aclk, .aresetn, .delay, .cpu_irq_valid, .cpu_svc,
      .cpu_take, .cpu_trap_done);
   // ----------
   // Tasks
   // ----------
   task automatic check(string nm, logic [33:0] seen, logic [33:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(logic [9:0] a, logic [31:0] d, logic [1:0] e = 0);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 0;
      wvalid <= 0;
      bready <= 1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 0;
      check("bresp", bresp, e);
   endtask
   task automatic rd(logic [9:0] a, logic [31:0] d, logic [1:0] e = 0);
      qr.push_back({e, d});
      araddr <= a;
      arvalid <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      rready <= 1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 0;
   endtask
   task automatic pulse(logic [111:0] r, logic [4:0] t = 0, logic [2:0] p = 0);
      src_req <= r;
      hw_trap <= t;
      srv_pin <= p;
      delay <= 4'($urandom % 6);
      @(posedge aclk);
      src_req <= 0;
      hw_trap <= 0;
      srv_pin <= 0;
      @(posedge aclk);
   endtask
   task automatic drain;
      for (int i = 0; i < 400 && qs.size() + qx.size() > 0; i++)
         @(posedge aclk);
      repeat (30) @(posedge aclk);
   endtask
   task automatic node(int n, logic [3:0] p, logic x = 0, logic [2:0] c = 0);
      wr(iets_pkg::A_NODE + 10'(4 * n), {22'h0, c, x, p, 2'b10});
   endtask
   // ----------
   // Result monitor
   // ----------
   always @(posedge aclk)
   begin
      if (rvalid === 1'b1 && rready === 1'b1)
         check("read", {rresp, rdata}, qr.size() ? qr.pop_front() : 'x);
      if (cpu_irq_valid === 1'b1 && cpu_take === 1'b1)
         check("svc", cpu_svc, qs.size() ? qs.pop_front() : 'x);
      if (xfer_valid === 1'b1)
         check("xfer", xfer, qx.size() ? qx.pop_front() : 'x);
   end
   initial
   begin
      repeat (40000) @(posedge aclk);
      n_fail++;
      print_verdict;
   end
   initial
   begin
      int n, lat;
      logic [15:0] s, d;
      logic [3:0] p;
      logic [31:0] k;
      void'($urandom(35));
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(iets_pkg::A_CTRL, 0);
      rd(10'h020, 0, iets_pkg::R_SLVERR);
      wr(10'h020, 32'hFFFF_FFFF, iets_pkg::R_SLVERR);
      for (int j = 0; j < 2; j++)
      begin
         n = 4 + $urandom % 104;
         p = 4'(1 + $urandom % 15);
         wr(iets_pkg::A_CTRL, 32'(1 - j));
         node(n, p);
         qs.push_back({1'b0, p, 8'(16 + n)});
         pulse(112'(1) << n);
         lat = 2;
         while (cpu_irq_valid !== 1'b1 && lat < 40)
         begin
            @(posedge aclk);
            lat++;
         end
         check("lat", lat, 2 + (j ? iets_pkg::LAT_NJ_CLK : 7));
         drain;
         qs.push_back({1'b0, p, 8'(16 + n)});
         wr(iets_pkg::A_NODE + 10'(4 * n), {26'h0, p, 2'b11});
         drain;
      end
      cpu_prio <= 2;
      node(20, 2);
      node(21, 6);
      node(22, 9);
      node(23, 9);
      qs = '{{5'h9, 8'h26}, {5'h9, 8'h27}, {5'h6, 8'h25}};
      pulse(112'hF << 20);
      drain;
      cpu_prio <= 3;
      qs.push_back({5'h3, 8'h7F});
      swi_num <= 7'h7F;
      swi_valid <= 1;
      do @(posedge aclk); while (swi_ready !== 1'b1);
      swi_valid <= 0;
      drain;
      qs.push_back({5'h2, 8'h24});
      cpu_prio <= 0;
      drain;
      wr(iets_pkg::A_MASK, 32'h100);
      for (int t = 0; t < 8; t++)
      begin
         node(30 + t, 1);
         qs.push_back({1'b1, iets_pkg::LVL_TRAP, 8'(t)});
         qs.push_back({5'h1, 8'(46 + t)});
         pulse(112'(1) << (30 + t), 5'(1 << t), 3'((1 << t) >> 5));
         drain;
         check("irq", irq, 1);
         rd(iets_pkg::A_TRAP, 32'(1) << t);
         wr(iets_pkg::A_TRAP, 32'(1) << t);
         wr(iets_pkg::A_STAT, 32'h100);
         check("irq", irq, 0);
      end
      wr(iets_pkg::A_MASK, 32'hFF);
      for (int c = 0; c < 8; c++)
      begin
         k = $urandom;
         s = 16'($urandom);
         d = 16'($urandom);
         wr(iets_pkg::A_CHAN + 10'(16 * c), {20'h0, c == 7, k[10:8], 8'h2});
         wr(iets_pkg::A_CHAN + 10'(16 * c + 4), {16'h0, s});
         wr(iets_pkg::A_CHAN + 10'(16 * c + 8), {16'h0, d});
         node(40 + c, 3, 1, 3'(c));
         for (int i = 0; i < 2; i++)
         begin
            qx.push_back({s, d, k[8]});
            if (i == 1 && c != 7)
               qs.push_back({5'h3, 8'(56 + c)});
            pulse(112'(1) << (40 + c));
            drain;
            s = s + (k[9] ? 16'(1 + k[8]) : 16'h0);
            d = d + (k[10] ? 16'(1 + k[8]) : 16'h0);
         end
         rd(iets_pkg::A_STAT, c == 7 ? 0 : 32'(1) << c);
         check("irq", irq, c != 7);
         wr(iets_pkg::A_STAT, 32'hFF);
      end
      node(0, 4);
      wr(iets_pkg::A_ROUTE, 32'h1);
      foreach (RT[i])
      begin
         wr(iets_pkg::A_RCFG, RT[i][36:5]);
         if (RT[i][0])
            qs.push_back({5'h4, 8'h10});
         router_in <= RT[i][4:1];
         @(posedge aclk);
         drain;
      end
      qs = '{{5'h4, 8'h10}, {5'h5, 8'h7C}};
      wr(iets_pkg::A_NODE, 32'h13);
      node(108, 5);
      wr(iets_pkg::A_SSEL, 32'h2);
      shared_src <= 16'h4;
      @(posedge aclk);
      shared_src <= 0;
      drain;
      print_verdict;
   end
endmodule // iets_top_tb
